// ---- rtl/drr_defs.svh ----
// Constants of the refresh-rate block: timing, mode codes, offsets.
// Assumes the clock period set by DRR_CLK_MHZ.
`ifndef DRR_DEFS_SVH
`define DRR_DEFS_SVH

`define DRR_CLK_MHZ 200
// Least times round up to whole cycles
`define DRR_CYC(ns) ((((ns) * `DRR_CLK_MHZ) + 999) / 1000)

`define DRR_RFC1_2G_NS 160
`define DRR_RFC1_4G_NS 260
`define DRR_RFC1_8G_NS 350
`define DRR_RFC1_16G_NS 550
`define DRR_RFC2_2G_NS 110
`define DRR_RFC2_4G_NS 160
`define DRR_RFC2_8G_NS 260
`define DRR_RFC2_16G_NS 350
`define DRR_RFC4_2G_NS 90
`define DRR_RFC4_4G_NS 110
`define DRR_RFC4_8G_NS 160
`define DRR_RFC4_16G_NS 260

`define DRR_DENS_2G 2'h0
`define DRR_DENS_4G 2'h1
`define DRR_DENS_8G 2'h2
`define DRR_DENS_16G 2'h3
`define DRR_DENS_RST 2'h0

`define DRR_MODE_FIX1X 3'h0
`define DRR_MODE_FIX2X 3'h1
`define DRR_MODE_FIX4X 3'h2
`define DRR_MODE_FLY12 3'h5
`define DRR_MODE_FLY14 3'h6

// Mode register select as {bank group, bank address}
`define DRR_SEL_MR3 4'h3
`define DRR_SEL_MR4 4'h4
`define DRR_MODE_MSB 8
`define DRR_MODE_LSB 6
`define DRR_TEMP_EN_BIT 3
`define DRR_TEMP_RANGE_BIT 2

// Case temperature thresholds in degrees C (45 and 85)
`define DRR_T_SLOW 8'h2D
`define DRR_T_NORM_MAX 8'h55

`define DRR_OFS_CTRL 4'h0
`define DRR_OFS_STATUS 4'h4
`define DRR_OFS_REFCNT 4'h8
`define DRR_OFS_EXECNT 4'hC

`endif

// ---- rtl/drr_pkg.sv ----
// Types of the refresh-rate block.
// Assumes drr_defs.svh for all numeric constants except the enum encodings defined here.
package drr_pkg;
    typedef enum logic [2:0] {
        DRR_REF1X = 3'b001,
        DRR_REF2X = 3'b010,
        DRR_REF4X = 3'b100
    } drr_ref_e;

    typedef enum logic [1:0] {
        DRR_IDLE = 2'b01,
        DRR_BUSY = 2'b10
    } drr_st_e;
endpackage : drr_pkg

// ---- rtl/drr_refresh_rate.sv ----
// Refresh-rate logic of a DRAM: mode decode, refresh type, skipping, cycle time.
// Assumes command pins from another domain and temp_c from an on-die sensor on clk_sys.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "drr_defs.svh"

// How it works
// - Below 45 C device skips some refreshes
// - Extended range 45 to 85 C skips half, below 45 C three in four
// - Skipping happens internally, no extra signalling
// - Mode write fixes rate or enables per-command choice
// - Three-bit mode field decode, reserved codes ignored
// - Per-command mode: bank-group bit picks refresh type
// - Reset gives fixed 1x mode
// - Cycle time depends on type and density
// - MR4 bit 3 enables, bit 2 picks range
module drr_refresh_rate import drr_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [31:0] avm_writedata,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    input wire logic pin_cs_n,
    input wire logic pin_act_n,
    input wire logic pin_ras_n,
    input wire logic pin_cas_n,
    input wire logic pin_we_n,
    input wire logic [1:0] pin_bg,
    input wire logic [1:0] pin_ba,
    input wire logic [13:0] pin_addr,
    input wire logic [7:0] temp_c,
    output logic int_refresh,
    output logic refresh_busy,
    output drr_ref_e exec_type
);
    logic [22:0] pin_meta;
    logic [22:0] pin_sync;
    logic [13:0] s_addr;
    logic [3:0] s_sel;
    logic is_ref;
    logic is_mrs;

    always_ff @(posedge clk_sys) begin
        pin_meta <= {pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n,
                     pin_bg, pin_ba, pin_addr};
        pin_sync <= pin_meta;
    end

    assign s_addr = pin_sync[13:0];
    assign s_sel = pin_sync[17:14];
    assign is_ref = (pin_sync[22:18] == 5'b01001);
    assign is_mrs = (pin_sync[22:18] == 5'b01000);

    function automatic logic [7:0] rfc_cycles(input drr_ref_e t, input logic [1:0] d);
        logic [7:0] c;
        c = 8'(`DRR_CYC(`DRR_RFC1_2G_NS));
        case ({t, d})
            {DRR_REF1X, `DRR_DENS_4G}: c = 8'(`DRR_CYC(`DRR_RFC1_4G_NS));
            {DRR_REF1X, `DRR_DENS_8G}: c = 8'(`DRR_CYC(`DRR_RFC1_8G_NS));
            {DRR_REF1X, `DRR_DENS_16G}: c = 8'(`DRR_CYC(`DRR_RFC1_16G_NS));
            {DRR_REF2X, `DRR_DENS_2G}: c = 8'(`DRR_CYC(`DRR_RFC2_2G_NS));
            {DRR_REF2X, `DRR_DENS_4G}: c = 8'(`DRR_CYC(`DRR_RFC2_4G_NS));
            {DRR_REF2X, `DRR_DENS_8G}: c = 8'(`DRR_CYC(`DRR_RFC2_8G_NS));
            {DRR_REF2X, `DRR_DENS_16G}: c = 8'(`DRR_CYC(`DRR_RFC2_16G_NS));
            {DRR_REF4X, `DRR_DENS_2G}: c = 8'(`DRR_CYC(`DRR_RFC4_2G_NS));
            {DRR_REF4X, `DRR_DENS_4G}: c = 8'(`DRR_CYC(`DRR_RFC4_4G_NS));
            {DRR_REF4X, `DRR_DENS_8G}: c = 8'(`DRR_CYC(`DRR_RFC4_8G_NS));
            {DRR_REF4X, `DRR_DENS_16G}: c = 8'(`DRR_CYC(`DRR_RFC4_16G_NS));
            default: c = 8'(`DRR_CYC(`DRR_RFC1_2G_NS));
        endcase
        return c;
    endfunction : rfc_cycles

    drr_st_e st, next_st;
    logic [7:0] rfc_cnt, next_rfc_cnt;
    logic [2:0] mode, next_mode;
    logic temp_controlled_refresh, next_temp_controlled_refresh;
    logic temp_range_ext, next_temp_range_ext;
    logic [1:0] gear, next_gear;
    logic [1:0] density, next_density;
    logic [15:0] ref_cnt, next_ref_cnt;
    logic [15:0] exe_cnt, next_exe_cnt;
    logic next_int_refresh;
    drr_ref_e next_exec_type;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    drr_ref_e type_dec;
    logic [2:0] code_in;
    logic code_ok;
    logic exec_ok;
    logic ref_take;
    logic on_the_fly_rate_select;

    assign code_in = s_addr[`DRR_MODE_MSB:`DRR_MODE_LSB];
    assign on_the_fly_rate_select = (mode == `DRR_MODE_FLY12) || (mode == `DRR_MODE_FLY14);
    assign ref_take = is_ref && (st == DRR_IDLE);

    always_comb begin
        code_ok = (code_in == `DRR_MODE_FIX1X) || (code_in == `DRR_MODE_FIX2X) ||
                  (code_in == `DRR_MODE_FIX4X) || (code_in == `DRR_MODE_FLY12) ||
                  (code_in == `DRR_MODE_FLY14);
        case (mode)
            `DRR_MODE_FIX2X: type_dec = DRR_REF2X;
            `DRR_MODE_FIX4X: type_dec = DRR_REF4X;
            `DRR_MODE_FLY12: type_dec = s_sel[2] ? DRR_REF2X : DRR_REF1X;
            `DRR_MODE_FLY14: type_dec = s_sel[2] ? DRR_REF4X : DRR_REF1X;
            default: type_dec = DRR_REF1X;
        endcase
        // Gear ratio: one in two or one in four external refreshes run
        exec_ok = 1'b1;
        if (temp_controlled_refresh) begin
            if (temp_c < `DRR_T_SLOW) begin
                exec_ok = temp_range_ext ? (gear == 2'h0) : !gear[0];
            end else if (temp_range_ext && (temp_c < `DRR_T_NORM_MAX)) begin
                exec_ok = !gear[0];
            end
        end
    end

    always_comb begin
        next_st = st;
        next_rfc_cnt = rfc_cnt;
        next_mode = mode;
        next_temp_controlled_refresh = temp_controlled_refresh;
        next_temp_range_ext = temp_range_ext;
        next_gear = gear;
        next_density = density;
        next_ref_cnt = ref_cnt;
        next_exe_cnt = exe_cnt;
        next_int_refresh = 1'b0;
        next_exec_type = exec_type;
        if (is_mrs && (s_sel == `DRR_SEL_MR3) && code_ok) begin
            next_mode = code_in;
        end
        if (is_mrs && (s_sel == `DRR_SEL_MR4)) begin
            next_temp_controlled_refresh = s_addr[`DRR_TEMP_EN_BIT];
            next_temp_range_ext = s_addr[`DRR_TEMP_RANGE_BIT];
            next_gear = 2'h0;
        end
        case (st)
            DRR_IDLE: begin
                if (is_ref) begin
                    next_ref_cnt = ref_cnt + 16'h0001;
                    if (temp_controlled_refresh) begin
                        next_gear = gear + 2'h1;
                    end
                    if (exec_ok) begin
                        next_exec_type = type_dec;
                        next_rfc_cnt = rfc_cycles(type_dec, density) - 8'h01;
                        next_st = DRR_BUSY;
                        next_int_refresh = 1'b1;
                        next_exe_cnt = exe_cnt + 16'h0001;
                    end
                end
            end
            DRR_BUSY: begin
                // Refresh commands are ignored here; MRS writes still apply
                if (rfc_cnt == 8'h00) begin
                    next_st = DRR_IDLE;
                end else begin
                    next_rfc_cnt = rfc_cnt - 8'h01;
                end
            end
            default: next_st = DRR_IDLE;
        endcase
        // Avalon slave: one wait cycle, then the answer
        next_waitrequest = !((avm_read || avm_write) && avm_waitrequest);
        next_readdata = 32'h0000_0000;
        if (avm_write && !avm_waitrequest && (avm_address == `DRR_OFS_CTRL)) begin
            next_density = avm_writedata[1:0];
        end
        if (avm_read && avm_waitrequest) begin
            case (avm_address)
                `DRR_OFS_CTRL: next_readdata = {30'h0, density};
                `DRR_OFS_STATUS: next_readdata = {23'h0, temp_range_ext,
                    temp_controlled_refresh, (st == DRR_BUSY), exec_type, mode};
                `DRR_OFS_REFCNT: next_readdata = {16'h0, ref_cnt};
                `DRR_OFS_EXECNT: next_readdata = {16'h0, exe_cnt};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= DRR_IDLE;
            rfc_cnt <= 8'h00;
            mode <= `DRR_MODE_FIX1X;
            temp_controlled_refresh <= 1'b0;
            temp_range_ext <= 1'b0;
            gear <= 2'h0;
            density <= `DRR_DENS_RST;
            ref_cnt <= 16'h0000;
            exe_cnt <= 16'h0000;
            int_refresh <= 1'b0;
            refresh_busy <= 1'b0;
            exec_type <= DRR_REF1X;
            avm_readdata <= 32'h0000_0000;
            avm_waitrequest <= 1'b1;
        end else begin
            st <= next_st;
            rfc_cnt <= next_rfc_cnt;
            mode <= next_mode;
            temp_controlled_refresh <= next_temp_controlled_refresh;
            temp_range_ext <= next_temp_range_ext;
            gear <= next_gear;
            density <= next_density;
            ref_cnt <= next_ref_cnt;
            exe_cnt <= next_exe_cnt;
            int_refresh <= next_int_refresh;
            refresh_busy <= (next_st == DRR_BUSY);
            exec_type <= next_exec_type;
            avm_readdata <= next_readdata;
            avm_waitrequest <= next_waitrequest;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_reset_mode;
        !$past(reset_n) |-> (mode == `DRR_MODE_FIX1X) && (exec_type == DRR_REF1X);
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode not 1x after reset");

    property p_mode_load;
        is_mrs && (s_sel == `DRR_SEL_MR3) && code_ok |=> mode == $past(code_in);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode field not taken");

    property p_mode_hold;
        !(is_mrs && (s_sel == `DRR_SEL_MR3) && code_ok) |=> $stable(mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed unasked");

    property p_fly_high;
        ref_take && exec_ok && on_the_fly_rate_select && s_sel[2] |=>
            (exec_type != DRR_REF1X) && int_refresh;
    endproperty
    a_fly_high: assert property (p_fly_high) else $error("fast refresh not chosen");

    property p_fixed4;
        ref_take && exec_ok && (mode == `DRR_MODE_FIX4X) |=> exec_type == DRR_REF4X;
    endproperty
    a_fixed4: assert property (p_fixed4) else $error("fixed 4x not applied");

    property p_rfc_load;
        ref_take && exec_ok |=> refresh_busy &&
            (rfc_cnt == $past(rfc_cycles(type_dec, density)) - 8'h01);
    endproperty
    a_rfc_load: assert property (p_rfc_load) else $error("cycle time wrong");

    property p_rfc_end;
        (st == DRR_BUSY) && (rfc_cnt == 8'h00) |=> !refresh_busy ##1 !refresh_busy || int_refresh;
    endproperty
    a_rfc_end: assert property (p_rfc_end) else $error("busy overran");

    property p_skip_norm;
        ref_take && temp_controlled_refresh && !temp_range_ext && (temp_c < `DRR_T_SLOW) && gear[0]
            |=> !int_refresh;
    endproperty
    a_skip_norm: assert property (p_skip_norm) else $error("cold refresh not skipped");

    property p_skip_ext;
        ref_take && temp_controlled_refresh && temp_range_ext && (temp_c >= `DRR_T_SLOW) &&
            (temp_c < `DRR_T_NORM_MAX) |=> int_refresh == !$past(gear[0]);
    endproperty
    a_skip_ext: assert property (p_skip_ext) else $error("extended gear wrong");

    property p_no_skip;
        ref_take && !temp_controlled_refresh |=> int_refresh ##1 !int_refresh;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("refresh lost");

    property p_temp_load;
        is_mrs && (s_sel == `DRR_SEL_MR4) |=>
            temp_controlled_refresh == $past(s_addr[`DRR_TEMP_EN_BIT]);
    endproperty
    a_temp_load: assert property (p_temp_load) else $error("MR4 enable not taken");
endmodule : drr_refresh_rate

// ---- testbench/drr_mc_model.sv ----
// Memory controller model: drives REFRESH and MRS onto the command pins.
// Assumes send is called just after a rising edge of clk_sys.
`timescale 1ns/1ps
module drr_mc_model (
    input wire logic clk_sys,
    output logic pin_cs_n,
    output logic pin_act_n,
    output logic pin_ras_n,
    output logic pin_cas_n,
    output logic pin_we_n,
    output logic [1:0] pin_bg,
    output logic [1:0] pin_ba,
    output logic [13:0] pin_addr
);
    time ready_at = 0;

    initial begin
        {pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n} = 5'h1F;
        {pin_bg, pin_ba, pin_addr} = 18'h00000;
    end

    // Cmd is {ras, cas, we}; gap is the deselect time in cycles that follows
    task automatic send(input logic [2:0] cmd, input logic [3:0] sel, input logic [13:0] a,
                        input int gap);
        while ($time < ready_at) @(posedge clk_sys);
        {pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n} <= {2'b01, cmd};
        {pin_bg, pin_ba, pin_addr} <= {sel, a};
        @(posedge clk_sys);
        // Deselected lines show the inverse, never a stale command
        {pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n} <= {1'b1, ~{1'b1, cmd}};
        {pin_bg, pin_ba, pin_addr} <= ~{sel, a};
        ready_at = $time + gap * 5;
    endtask : send
endmodule : drr_mc_model

// ---- testbench/testbench.sv ----
// Testbench of the refresh-rate block: register bus, command pins, temperature.
// Assumes drr_mc_model drives the pins and the design holds its own assertions.
`timescale 1ns/1ps
`include "drr_defs.svh"
module testbench import drr_pkg::*; ;
    typedef struct packed {
        logic [2:0] mode;
        logic bg0;
        logic [1:0] dens;
        drr_ref_e et;
        int ns;
    } drr_row_s;
    typedef struct packed {
        logic ext;
        logic [7:0] t;
        logic [2:0] n;
    } drr_temp_s;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avm_address = 4'h0;
    logic avm_read = 1'b0;
    logic avm_write = 1'b0;
    logic [31:0] avm_writedata = 32'h0;
    logic [31:0] avm_readdata;
    logic avm_waitrequest;
    logic pin_cs_n, pin_act_n, pin_ras_n, pin_cas_n, pin_we_n;
    logic [1:0] pin_bg, pin_ba;
    logic [13:0] pin_addr;
    logic [7:0] temp_c = 8'h19;
    logic int_refresh, refresh_busy;
    drr_ref_e exec_type;
    int n_errors = 0;
    int checks_done = 0;
    int n_pulse = 0;
    logic [31:0] q, base;
    logic [2:0] rsv [3] = '{3'h3, 3'h4, 3'h7};
    drr_row_s rows [7] = '{
        '{`DRR_MODE_FIX1X, 1'b1, `DRR_DENS_8G, DRR_REF1X, `DRR_RFC1_8G_NS},
        '{`DRR_MODE_FIX2X, 1'b0, `DRR_DENS_16G, DRR_REF2X, `DRR_RFC2_16G_NS},
        '{`DRR_MODE_FIX4X, 1'b1, `DRR_DENS_2G, DRR_REF4X, `DRR_RFC4_2G_NS},
        '{`DRR_MODE_FLY12, 1'b0, `DRR_DENS_4G, DRR_REF1X, `DRR_RFC1_4G_NS},
        '{`DRR_MODE_FLY12, 1'b1, `DRR_DENS_8G, DRR_REF2X, `DRR_RFC2_8G_NS},
        '{`DRR_MODE_FLY14, 1'b1, `DRR_DENS_16G, DRR_REF4X, `DRR_RFC4_16G_NS},
        '{`DRR_MODE_FLY14, 1'b0, `DRR_DENS_2G, DRR_REF1X, `DRR_RFC1_2G_NS}};
    // Temperatures sit on both sides of the 45 and 85 thresholds
    drr_temp_s temp_rows [6] = '{'{1'b0, 8'h2C, 3'h2}, '{1'b0, 8'h2D, 3'h4},
        '{1'b1, 8'h2C, 3'h1},
        '{1'b1, 8'h2D, 3'h2}, '{1'b1, 8'h54, 3'h2}, '{1'b1, 8'h55, 3'h4}};

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (int_refresh === 1'b1) n_pulse++;

    drr_refresh_rate dut_u (.clk_sys, .reset_n, .avm_address, .avm_read, .avm_write,
        .avm_writedata, .avm_readdata, .avm_waitrequest, .pin_cs_n, .pin_act_n, .pin_ras_n,
        .pin_cas_n, .pin_we_n, .pin_bg, .pin_ba, .pin_addr, .temp_c, .int_refresh,
        .refresh_busy, .exec_type);
    drr_mc_model mc_u (.clk_sys, .pin_cs_n, .pin_act_n, .pin_ras_n, .pin_cas_n, .pin_we_n,
        .pin_bg, .pin_ba, .pin_addr);

    task automatic wrap_up;
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        avm_address <= a;
        avm_writedata <= d;
        avm_write <= wr;
        avm_read <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (avm_waitrequest === 1'b0) break;
        end
        q = avm_readdata;
        avm_read <= 1'b0;
        avm_write <= 1'b0;
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
    endtask : bus

    function automatic int cyc(input int ns);
        return (ns * 200 + 999) / 1000;
    endfunction : cyc

    // Pulse must come 3 cycles after the pins, busy must last the cycle time
    task automatic ref_check(input logic bg0, input drr_ref_e et, input int ncyc);
        int n;
        int b;
        mc_u.send(3'b001, {1'b0, bg0, 2'h0}, 14'h0, 120);
        for (n = 1; n <= 10; n++) begin
            @(posedge clk_sys);
            if (int_refresh === 1'b1) break;
        end
        chk(n, 3);
        chk(32'(exec_type), 32'(et));
        for (b = 1; b < 200; b++) begin
            @(posedge clk_sys);
            if (refresh_busy !== 1'b1) break;
        end
        chk(b, ncyc);
        if (n > 10 || b == 200) wrap_up();
    endtask : ref_check

    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
    endtask : do_reset

    initial begin
        do_reset();
        foreach (rows[i]) begin
            bus(1'b1, `DRR_OFS_CTRL, 32'(rows[i].dens));
            mc_u.send(3'b000, `DRR_SEL_MR3, {5'h0, rows[i].mode, 6'h0}, 4);
            ref_check(rows[i].bg0, rows[i].et, cyc(rows[i].ns));
            bus(1'b0, `DRR_OFS_STATUS, 32'h0);
            chk(32'(q[5:0]), 32'({rows[i].et, rows[i].mode}));
        end
        foreach (rsv[j]) mc_u.send(3'b000, `DRR_SEL_MR3, {5'h0, rsv[j], 6'h0}, 4);
        mc_u.send(3'b000, `DRR_SEL_MR4, 14'h0, 4);
        bus(1'b0, `DRR_OFS_STATUS, 32'h0);
        chk(32'({q[8:7], q[2:0]}), 32'(`DRR_MODE_FLY14));
        // Second refresh lands inside the first one's cycle time
        bus(1'b0, `DRR_OFS_REFCNT, 32'h0);
        base = q;
        mc_u.send(3'b001, 4'h0, 14'h0, 6);
        mc_u.send(3'b001, 4'h0, 14'h0, 4);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, `DRR_OFS_REFCNT, 32'h0);
        chk(q - base, 32'h1);
        mc_u.send(3'b000, `DRR_SEL_MR3, 14'h0, 4);
        foreach (temp_rows[i]) begin
            temp_c <= temp_rows[i].t;
            mc_u.send(3'b000, `DRR_SEL_MR4, {11'h0, 1'b1, temp_rows[i].ext, 2'h0}, 4);
            base = n_pulse;
            repeat (4) mc_u.send(3'b001, 4'h0, 14'h0, 120);
            repeat (10) @(posedge clk_sys);
            chk(n_pulse - base, 32'(temp_rows[i].n));
        end
        do_reset();
        bus(1'b0, `DRR_OFS_STATUS, 32'h0);
        chk(q, 32'h8);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, `DRR_OFS_CTRL, 32'h0);
        chk(q, 32'(`DRR_DENS_RST));
        ref_check(1'b1, DRR_REF1X, cyc(`DRR_RFC1_2G_NS));
        bus(1'b0, `DRR_OFS_REFCNT, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, `DRR_OFS_EXECNT, 32'h0);
        chk(q, 32'h1);
        wrap_up();
    end
endmodule : testbench
